// [core/acs_pkg.sv]
// package: register map, field layout and timing constants of the conversion sequencer
package acs_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_RESULT  = 6'h19;
  localparam logic [5:0] IDX_CHANSEL = 6'h1A;
  localparam logic [5:0] IDX_TRIGCTL = 6'h1B;
  localparam logic [5:0] IDX_CTRL    = 6'h1C;

  // ----------------------------------------------------------------
  // conv_control_status fields
  // ----------------------------------------------------------------
  localparam int CTRL_ON_BIT    = 7;
  localparam int CTRL_START_BIT = 6;
  localparam int CTRL_ATE_BIT   = 5;
  localparam int CTRL_FLAG_BIT  = 4;
  localparam int CTRL_IE_BIT    = 3;
  localparam int CTRL_DIV_LSB   = 0;
  localparam int DIV_W          = 3;
  localparam int CHAN_W         = 2;
  localparam int TSEL_W         = 3;
  localparam int NUM_TRIG       = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]        RST_RESULT = 8'h00;
  localparam logic [CHAN_W-1:0] RST_CHAN   = 2'h0;
  localparam logic [TSEL_W-1:0] RST_TSEL   = 3'h0;
  localparam logic [DIV_W-1:0]  RST_DIV    = 3'h0;
  localparam logic [TSEL_W-1:0] TSEL_FREE  = 3'h0;

  // ----------------------------------------------------------------
  // timing in converter clock cycles
  // ----------------------------------------------------------------
  localparam logic [4:0] CONV_CYC_FIRST  = 5'd25;
  localparam logic [4:0] CONV_CYC_NORMAL = 5'd13;
  localparam logic [4:0] SH_IDX_FIRST    = 5'd15;
  localparam logic [4:0] SH_IDX_NORMAL   = 5'd2;
  localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;

  typedef enum logic {ACS_IDLE, ACS_CONV} acs_state_e;
endpackage

// [core/acs_presc_if.sv]
// interface: control and tick between sequencer and prescaler
`timescale 1ns/1ps
`default_nettype none
interface acs_presc_if;
  logic                    clear;
  logic [acs_pkg::DIV_W-1:0] sel;
  logic                    tick;
  modport ctl (output clear, output sel, input tick);
  modport div (input clear, input sel, output tick);
endinterface
`default_nettype wire

// [core/acs_prescaler.sv]
// module: converter clock prescaler, one-cycle tick per converter clock
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // control from sequencer
  acs_presc_if.div  pif
);
  logic [CNT_W-1:0] cnt_r;
  logic             tick_r;
  logic [CNT_W-1:0] term;

  // codes 0 and 1 both divide by two
  assign term = (pif.sel < 3'd2) ? CNT_W'(1) : CNT_W'((1 << pif.sel) - 1);
  assign pif.tick = tick_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (ce) begin
      if (pif.clear) begin
        cnt_r  <= '0;
        tick_r <= 1'b0;
      end else begin
        cnt_r  <= (cnt_r == term) ? '0 : cnt_r + CNT_W'(1);
        tick_r <= (cnt_r == term);
      end
    end
  end
endmodule
`default_nettype wire

// [core/acs_sequencer.sv]
// module: conversion sequencer top with apb register slave and successive-approximation control
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - channel written mid-conversion is held and applied once that conversion completes
// - free-running: a late channel change skips the conversion already under way
// - input above reference gives all ones, never wraps
// - enabled, idle, single mode, irq on, cpu halted in sleep: conversion starts
// - sleep-started conversion still raises completion request after early wakeup
// - deep sleep does not switch the converter off by itself
// - result is input times 256 over reference, zero is ground
// - upper six bits of channel register read zero
// - channel code n connects input n
// - enable bit on turns converter on, off aborts conversion
// - start bit starts every single conversion, only the first free-running one
// - first conversion after enable takes 25 converter cycles, later ones 13
// - start bit reads one while converting, writing zero does nothing
// - auto-trigger starts a conversion on a rising edge of selected source seen while idle; edges during a conversion are ignored
// - done flag sets on completion with result; irq requested while enabled
// - done flag clears on vector acknowledge or written one
// - three-bit prescaler divides by 2,2,4,8,16,32,64,128
// - trigger select: zero is free running, ignored while auto-trigger off
// - control bit 3 enables the completion interrupt request
// - free-running restarts right after each completion, start bit stays high
module acs_sequencer (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // trigger sources for select codes 1 to 7
  input  wire logic [6:0]  trig_src,
  // cpu sleep status and interrupt acknowledge
  input  wire logic        cpu_halted,
  input  wire logic        sleep_nr_idle,
  input  wire logic        irq_ack,
  // analog front end
  input  wire logic        comp_in,
  output logic      [1:0]  adc_chan,
  output logic      [7:0]  adc_dac,
  output logic             adc_sample,
  output logic             adc_on,
  // interrupt request
  output logic             conv_irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  acs_pkg::acs_state_e                 state_r;
  logic                                converter_on_r;
  logic                                start_pend_r;
  logic                                auto_trigger_on_r;
  logic                                conv_done_flag_r;
  logic                                conv_done_irq_on_r;
  logic [acs_pkg::DIV_W-1:0]           clock_div_sel_r;
  logic [acs_pkg::CHAN_W-1:0]          channel_sel_r;
  logic [acs_pkg::TSEL_W-1:0]          trigger_source_sel_r;
  logic [7:0]                          result_r;
  logic [acs_pkg::CHAN_W-1:0]          chan_act_r;
  logic                                first_pend_r;
  logic                                first_conv_r;
  logic [4:0]                          cnt_r;
  logic [7:0]                          sar_r;
  logic [7:0]                          mask_r;
  logic                                sample_r;
  logic                                trig_prev_r;
  logic                                halt_prev_r;
  logic [31:0]                         prdata_r;
  logic                                pready_r;
  logic                                pslverr_r;
  logic                                irq_r;

  acs_presc_if presc ();

  acs_prescaler u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pif     (presc)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire       acc_phase = psel & penable;
  wire       wr_fire   = acc_phase & pwrite & pready_r;
  wire [5:0] idx       = paddr[7:2];
  wire       hit_ctrl  = (idx == acs_pkg::IDX_CTRL);
  wire       hit_chan  = (idx == acs_pkg::IDX_CHANSEL);
  wire       hit_trig  = (idx == acs_pkg::IDX_TRIGCTL);
  wire       hit_res   = (idx == acs_pkg::IDX_RESULT);
  wire       hit_any   = hit_ctrl | hit_chan | hit_trig | hit_res;
  wire       wr_ctrl   = wr_fire & hit_ctrl;
  wire       wr_chan   = wr_fire & hit_chan;
  wire       wr_trig   = wr_fire & hit_trig;

  // ----------------------------------------------------------------
  // sequencing terms
  // ----------------------------------------------------------------
  wire busy      = (state_r == acs_pkg::ACS_CONV);
  wire tick      = presc.tick;
  wire [4:0] last_idx = first_conv_r ? acs_pkg::CONV_CYC_FIRST - 5'd1 : acs_pkg::CONV_CYC_NORMAL - 5'd1;
  wire [4:0] sh_idx   = first_conv_r ? acs_pkg::SH_IDX_FIRST : acs_pkg::SH_IDX_NORMAL;
  wire last_cyc  = busy & (cnt_r == last_idx);
  // an abort landing on the last tick must neither set the flag nor write the result
  wire done      = last_cyc & tick & converter_on_r;
  wire bit_tick  = busy & tick & (cnt_r > sh_idx) & (mask_r != 8'h00);
  wire free_run  = auto_trigger_on_r & (trigger_source_sel_r == acs_pkg::TSEL_FREE);
  wire idle_free = ~busy & ~start_pend_r & converter_on_r;
  // source zero never triggers by edge; free running restarts on completion instead
  wire trig_sig  = (trigger_source_sel_r == acs_pkg::TSEL_FREE) ? 1'b0
                   : trig_src[trigger_source_sel_r - acs_pkg::TSEL_W'(1)];
  wire auto_go   = idle_free & auto_trigger_on_r & trig_sig & ~trig_prev_r;
  wire sleep_go  = idle_free & ~auto_trigger_on_r & conv_done_irq_on_r
                   & sleep_nr_idle & cpu_halted & ~halt_prev_r;
  wire sw_go     = wr_ctrl & pwdata[acs_pkg::CTRL_START_BIT]
                   & pwdata[acs_pkg::CTRL_ON_BIT] & ~busy;
  wire launch    = start_pend_r & tick & converter_on_r & ~busy;
  wire flag_clr  = irq_ack | (wr_ctrl & pwdata[acs_pkg::CTRL_FLAG_BIT]);

  // trigger restarts the prescaler for a fixed delay to conversion start
  assign presc.clear = ~converter_on_r | auto_go;
  assign presc.sel   = clock_div_sel_r;

  // comparator keeps or drops the trial bit; all-high input ends at all ones
  wire [7:0] sar_step = (comp_in ? sar_r : (sar_r & ~mask_r)) | (mask_r >> 1);

  // ----------------------------------------------------------------
  // control and status registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on_r       <= 1'b0;
      auto_trigger_on_r    <= 1'b0;
      conv_done_irq_on_r   <= 1'b0;
      clock_div_sel_r      <= acs_pkg::RST_DIV;
      channel_sel_r        <= acs_pkg::RST_CHAN;
      trigger_source_sel_r <= acs_pkg::RST_TSEL;
    end else if (ce) begin
      if (wr_ctrl) begin
        // sleep state never touches this bit; software must clear it
        converter_on_r     <= pwdata[acs_pkg::CTRL_ON_BIT];
        auto_trigger_on_r  <= pwdata[acs_pkg::CTRL_ATE_BIT];
        conv_done_irq_on_r <= pwdata[acs_pkg::CTRL_IE_BIT];
        clock_div_sel_r    <= pwdata[acs_pkg::CTRL_DIV_LSB +: acs_pkg::DIV_W];
      end
      if (wr_chan) begin
        channel_sel_r <= pwdata[acs_pkg::CHAN_W-1:0];
      end
      if (wr_trig) begin
        trigger_source_sel_r <= pwdata[acs_pkg::TSEL_W-1:0];
      end
    end
  end

  // set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done_flag_r <= 1'b0;
    end else if (ce) begin
      if (done) begin
        conv_done_flag_r <= 1'b1;
      end else if (flag_clr) begin
        conv_done_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // start requests and first-conversion marker
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pend_r <= 1'b0;
      first_pend_r <= 1'b1;
      trig_prev_r  <= 1'b0;
      halt_prev_r  <= 1'b0;
    end else if (ce) begin
      trig_prev_r <= trig_sig;
      halt_prev_r <= cpu_halted;
      if (!converter_on_r) begin
        // covers a start written together with the enable
        first_pend_r <= 1'b1;
        start_pend_r <= sw_go;
      end else if (launch) begin
        first_pend_r <= 1'b0;
        start_pend_r <= 1'b0;
      end else if (sw_go | auto_go | sleep_go) begin
        start_pend_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion engine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= acs_pkg::ACS_IDLE;
      cnt_r        <= 5'd0;
      first_conv_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        acs_pkg::ACS_IDLE: begin
          if (launch) begin
            state_r      <= acs_pkg::ACS_CONV;
            cnt_r        <= 5'd0;
            first_conv_r <= first_pend_r;
          end
        end
        acs_pkg::ACS_CONV: begin
          if (!converter_on_r) begin
            state_r <= acs_pkg::ACS_IDLE;
          end else if (done) begin
            cnt_r        <= 5'd0;
            first_conv_r <= 1'b0;
            if (!free_run) begin
              state_r <= acs_pkg::ACS_IDLE;
            end
          end else if (tick) begin
            cnt_r <= cnt_r + 5'd1;
          end
        end
        default: begin
          state_r <= acs_pkg::ACS_IDLE;
        end
      endcase
    end
  end

  // free running simply stays in conversion on completion
  wire restart = done & free_run;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_r    <= 8'h00;
      mask_r   <= 8'h00;
      sample_r <= 1'b0;
      result_r <= acs_pkg::RST_RESULT;
    end else if (ce) begin
      sample_r <= busy & tick & (cnt_r == sh_idx) & converter_on_r;
      if (busy & tick & (cnt_r == sh_idx)) begin
        sar_r  <= acs_pkg::SAR_FIRST_TRIAL;
        mask_r <= acs_pkg::SAR_FIRST_TRIAL;
      end else if (bit_tick) begin
        sar_r  <= sar_step;
        mask_r <= mask_r >> 1;
      end
      if (done & converter_on_r) begin
        result_r <= sar_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // channel hold: follows software except while a conversion is locked
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_act_r <= acs_pkg::RST_CHAN;
    end else if (ce) begin
      // the selection only takes effect once enabled
      if (converter_on_r & (~busy | last_cyc) & ~restart) begin
        chan_act_r <= channel_sel_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb answer: one wait state, registered data
  // ----------------------------------------------------------------
  wire start_rd = busy | start_pend_r;
  wire [7:0] ctrl_rd = {converter_on_r, start_rd, auto_trigger_on_r, conv_done_flag_r,
                        conv_done_irq_on_r, clock_div_sel_r};
  wire [7:0] rd_byte = hit_ctrl ? ctrl_rd
                     : hit_chan ? {6'h00, channel_sel_r}
                     : hit_trig ? {5'h00, trigger_source_sel_r}
                     : hit_res  ? result_r
                     : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (ce) begin
      pready_r  <= acc_phase & ~pready_r;
      pslverr_r <= acc_phase & ~pready_r & ~hit_any;
      prdata_r  <= (acc_phase & ~pready_r & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // request stands from the flag and the interrupt enable bit, so an early wakeup still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= conv_done_flag_r & conv_done_irq_on_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign adc_chan   = chan_act_r;
  assign adc_dac    = sar_r;
  assign adc_sample = sample_r;
  assign adc_on     = converter_on_r;
  assign conv_irq   = irq_r;
endmodule
`default_nettype wire

// [tb/acs_sequencer_asserts.sv]
// checker: concurrent assertions on the conversion sequencer ports
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_asserts (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // converter side
  input wire logic        irq_ack,
  input wire logic [1:0]  adc_chan,
  input wire logic [7:0]  adc_dac,
  input wire logic        adc_sample,
  input wire logic        adc_on,
  input wire logic        conv_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_access;
    psel && penable && ce;
  endsequence
  a_ready_one_wait: assert property (s_setup ##1 s_access |=> pready) else $error("apb answer not on 2nd access cycle");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready && psel && penable) else $error("pslverr outside answer");
  a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0000_0000) else $error("prdata not zero");
  a_rdata_upper: assert property (prdata[31:8] == 24'h00_0000) else $error("prdata upper bits set");
  // ----------------------------------------------------------------
  // conversion
  // ----------------------------------------------------------------
  a_sample_when_on: assert property (adc_sample |-> adc_on) else $error("sample while off");
  a_sample_gap: assert property (adc_sample |=> !adc_sample [*8]) else $error("samples too close");
  a_chan_locked: assert property (adc_sample |=> ($stable(adc_chan) || !adc_on) [*8]) else $error("chan moved");
  a_trial_msb: assert property (adc_sample |-> ##[0:300] adc_dac == 8'h80) else $error("no msb trial");
  a_ack_clears: assert property (irq_ack && conv_irq |-> ##[1:3] !conv_irq) else $error("ack kept irq");
  a_ce_freeze: assert property (!ce |=> $stable(adc_dac) && $stable(adc_chan) && $stable(conv_irq))
    else $error("state moved while ce low");
endmodule
`default_nettype wire

// [tb/test_acs_sequencer.sv]
// testbench: register, conversion, trigger and sleep scenarios for the sequencer
`timescale 1ns/1ps
`default_nettype none
module test_acs_sequencer;
  localparam logic [5:0] RES = acs_pkg::IDX_RESULT, CHS = acs_pkg::IDX_CHANSEL;
  localparam logic [5:0] TRG = acs_pkg::IDX_TRIGCTL, CTL = acs_pkg::IDX_CTRL;
  localparam logic [7:0] ON = 8'h80, ST = 8'h40, ATE = 8'h20, FLG = 8'h10, IE = 8'h08;
  logic        pclk, presetn, ce, psel, penable, pwrite;
  logic [7:0]  paddr, adc_dac;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, cpu_halted, sleep_nr_idle, irq_ack, comp_in;
  logic [6:0]  trig_src;
  logic [1:0]  adc_chan;
  logic        adc_sample, adc_on, conv_irq;
  logic [8:0]  vin [4];
  logic [32:0] expq [$];
  int          fails, num_checks, cyc, t0, d, n;
  // ideal comparator; above-reference inputs stay high on every trial
  assign comp_in = vin[adc_chan] >= {1'b0, adc_dac};
  acs_sequencer u_acs_sequencer (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trig_src, .cpu_halted, .sleep_nr_idle, .irq_ack, .comp_in, .adc_chan, .adc_dac,
    .adc_sample, .adc_on, .conv_irq);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int c, input int lo, input int hi);
    num_checks++;
    if (c < lo || c > hi) begin
      fails++;
      $display("ERROR t=%0t cycles %0d not in %0d..%0d", $time, c, lo, hi);
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) chk({pslverr, prdata}, expq.pop_front());
  end
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] dat);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, dat};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk(33'h0, 33'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] dat);
    bus(1'b1, idx, dat);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [32:0] e);
    expq.push_back(e);
    bus(1'b0, idx, 8'h00);
  endtask
  task automatic wait_irq;
    int k;
    k = 0;
    while (conv_irq !== 1'b1 && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 5000) chk(33'h0, 33'h1);
  endtask
  task automatic ack;
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic pulse(input int k);
    trig_src[k-1] <= 1'b1;
    repeat (3) @(posedge pclk);
    trig_src[k-1] <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [32:0] ex(input int ch);
    return (vin[ch] > 9'h0ff) ? 33'h0ff : 33'(vin[ch]);
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, irq_ack, cpu_halted, sleep_nr_idle, presetn} = '0;
    {paddr, pwdata, trig_src, cyc, fails, num_checks} = '0;
    ce = 1'b1;
    for (int i = 0; i < 4; i++) vin[i] = 9'h000;
    void'($urandom(32'hf86718dc));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(RES, 33'h0);
    rd(TRG, 33'h0);
    rd(CTL, 33'h0);
    wr(6'h05, 8'hff);
    rd(6'h05, 33'h1_0000_0000);
    wr(CHS, 8'hfe);
    rd(CHS, 33'h2);
    wr(RES, 8'h5a);
    rd(RES, 33'h0);
    wr(CTL, ST);
    rd(CTL, 33'h0);
    $display("test regs done");
    for (int i = 0; i < 8; i++) begin
      d = (i < 2) ? 2 : (1 << i);
      wr(CTL, ON | ST | IE | 8'(i));
      t0 = cyc;
      wait_irq;
      chk_rng(cyc - t0, 25 * d, 26 * d + 4);
      wr(CTL, 8'h00);
      ack;
    end
    $display("test divider done");
    for (int ch = 0; ch < 4; ch++) vin[ch] <= (ch == 3) ? 9'(9'h100 + $urandom_range(255)) : 9'($urandom_range(255));
    wr(CTL, ON | IE);
    for (int ch = 0; ch < 4; ch++) begin
      n = (ch == 0) ? 25 : 13;
      wr(CHS, 8'(ch));
      wr(CTL, ON | ST | IE);
      t0 = cyc;
      rd(CTL, 33'(ON | ST | IE));
      wr(CTL, ON | IE);
      rd(CTL, 33'(ON | ST | IE));
      wait_irq;
      chk_rng(cyc - t0, 2 * n - 4, 2 * n + 4);
      chk(33'(adc_chan), 33'(ch));
      rd(CTL, 33'(ON | FLG | IE));
      rd(RES, ex(ch));
      if (ch[0]) ack;
      else wr(CTL, ON | FLG | IE);
      rd(CTL, 33'(ON | IE));
    end
    $display("test channels done");
    wr(CHS, 8'h00);
    wr(CTL, ON | ST | IE);
    repeat (4) @(posedge pclk);
    wr(CHS, 8'h02);
    chk(33'(adc_chan), 33'h0);
    // clock enable low mid-conversion: the trial code must hold still
    ce <= 1'b0;
    @(posedge pclk);
    t0 = adc_dac;
    repeat (40) @(posedge pclk);
    chk(33'(adc_dac), 33'(t0));
    ce <= 1'b1;
    wait_irq;
    rd(RES, ex(0));
    chk(33'(adc_chan), 33'h2);
    ack;
    wr(CTL, 8'h00);
    wr(CTL, ON | ST | IE);
    wr(CTL, IE);
    rd(CTL, 33'(IE));
    repeat (80) @(posedge pclk);
    chk({conv_irq, adc_on}, 33'h0);
    rd(RES, ex(0));
    $display("test abort done");
    wr(CTL, ON | IE);
    for (int k = 1; k < 8; k++) begin
      wr(TRG, 8'(k));
      rd(TRG, 33'(k));
      pulse(k);
      repeat (40) @(posedge pclk);
      chk(33'(conv_irq), 33'h0);
      wr(CTL, ON | ATE | IE);
      pulse(k);
      wait_irq;
      rd(RES, ex(2));
      wr(CTL, ON | IE);
      ack;
    end
    $display("test trigger done");
    wr(TRG, 8'h00);
    wr(CHS, 8'h00);
    wr(CTL, ON | ST | ATE | IE);
    wait_irq;
    wr(CHS, 8'h01);
    ack;
    wait_irq;
    rd(CTL, 33'(ON | ST | ATE | FLG | IE));
    rd(RES, ex(0));
    ack;
    wait_irq;
    rd(RES, ex(1));
    wr(CTL, 8'h00);
    ack;
    $display("test free running done");
    wr(CTL, ON | IE);
    cpu_halted <= 1'b1;
    repeat (60) @(posedge pclk);
    chk({conv_irq, adc_on}, 33'h1);
    cpu_halted <= 1'b0;
    sleep_nr_idle <= 1'b1;
    @(posedge pclk);
    cpu_halted <= 1'b1;
    repeat (6) @(posedge pclk);
    cpu_halted <= 1'b0;
    rd(CTL, 33'(ON | ST | IE));
    wait_irq;
    chk(33'(conv_irq), 33'h1);
    rd(CTL, 33'(ON | FLG | IE));
    ack;
    $display("test sleep done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CTL, 33'h0);
    rd(CHS, 33'h0);
    $display("test second reset done");
    wrap_up;
  end
  // whole sequence needs about 8500 cycles; seven times that is a hang
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    wrap_up;
  end
endmodule
bind acs_sequencer acs_sequencer_asserts u_acs_sequencer_asserts (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .irq_ack, .adc_chan, .adc_dac, .adc_sample, .adc_on, .conv_irq);
`default_nettype wire
